//--- hw/embc_pkg.sv
// shared constants, types and timing counts of the external bus cycle block
package embc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // bus geometry
    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;
    localparam int SPACE_WORDS = 65536;

    ////////////////////////////////////////////////////////////////////////
    // clock and quarter phase timing
    localparam int CLK_NS = 10;
    localparam int REF_CLKOUT_MHZ = 40;
    localparam int QPHASE_NS = 25;
    // quarter phase rounded up to whole system clocks
    localparam int Q_CYC = (QPHASE_NS + CLK_NS - 1) / CLK_NS;
    localparam int MC_CYC = 4 * Q_CYC;

    // address valid to strobe low, least time
    localparam int STROBE_SETUP_NS = QPHASE_NS - 12;
    localparam int STROBE_SETUP_CYC_RAW =
        (STROBE_SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int STROBE_SETUP_CYC = (STROBE_SETUP_CYC_RAW < 1) ? 1 :
                                      STROBE_SETUP_CYC_RAW;
    // strobe low to ready stable, longest time
    localparam int READY_STABLE_NS = QPHASE_NS - 20;
    localparam int READY_STABLE_CYC_RAW = READY_STABLE_NS / CLK_NS;
    localparam int READY_STABLE_CYC = (READY_STABLE_CYC_RAW < 1) ? 1 :
                                      READY_STABLE_CYC_RAW;
    // strobe low to read data valid, longest time
    localparam int DATA_VALID_NS = 2 * QPHASE_NS - 23;
    localparam int DATA_VALID_CYC_RAW = DATA_VALID_NS / CLK_NS;
    localparam int DATA_VALID_CYC = (DATA_VALID_CYC_RAW < 1) ? 1 :
                                    DATA_VALID_CYC_RAW;
    // strobe high to write data released, longest time
    localparam int WR_RELEASE_NS = QPHASE_NS + 15;
    localparam int WR_RELEASE_CYC_RAW = WR_RELEASE_NS / CLK_NS;
    localparam int WR_RELEASE_CYC = (WR_RELEASE_CYC_RAW < 1) ? 1 :
                                    WR_RELEASE_CYC_RAW;

    ////////////////////////////////////////////////////////////////////////
    // positions inside one machine cycle, in system clocks
    localparam int STROBE_POS_I = (Q_CYC > STROBE_SETUP_CYC) ? Q_CYC :
                                  STROBE_SETUP_CYC;
    localparam int SAMPLE_POS_I =
        (2 * Q_CYC > STROBE_POS_I + READY_STABLE_CYC) ?
        2 * Q_CYC : STROBE_POS_I + READY_STABLE_CYC;
    localparam logic [3:0] POS_FIRST = 4'h0;
    localparam logic [3:0] POS_LAST = 4'(MC_CYC - 1);
    localparam logic [3:0] POS_STROBE = 4'(STROBE_POS_I);
    localparam logic [3:0] POS_SAMPLE = 4'(SAMPLE_POS_I);
    localparam logic [3:0] POS_CLK1_HIGH = 4'(2 * Q_CYC);

    ////////////////////////////////////////////////////////////////////////
    // select codes, pin reset values and wait count cap, select lines are active low
    localparam logic [2:0] SEL_NONE = 3'h7;
    localparam logic [2:0] SEL_PROG = 3'h6;
    localparam logic [2:0] SEL_DATA = 3'h5;
    localparam logic [2:0] SEL_IO = 3'h3;
    localparam logic [15:0] ADDR_RST = 16'h0000;
    localparam logic [15:0] DATA_RST = 16'h0000;
    localparam logic [3:0] WAITS_MAX = 4'hf;

    ////////////////////////////////////////////////////////////////////////
    // types
    typedef enum logic [1:0] {
        SP_PROG = 2'b00,
        SP_DATA = 2'b01,
        SP_IO = 2'b10
    } embc_space_t;

    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_ACCESS = 1'b1
    } embc_state_t;

    typedef struct packed {
        embc_space_t space;
        logic write;
        logic onchip;
        logic [15:0] addr;
        logic [15:0] wdata;
    } embc_req_t;

    typedef struct packed {
        logic write;
        logic [3:0] waits;
        logic [15:0] rdata;
    } embc_resp_t;

endpackage

//--- hw/embc_qtimer.sv
// quarter phase timer: position in machine cycle and first output clock
module embc_qtimer (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic ce,
    output logic [3:0] pos,
    output logic first_output_clock
);
    import embc_pkg::*;

    logic [3:0] pos_r;
    logic [3:0] pos_nxt;
    logic clk1_r;
    logic clk1_nxt;

    assign pos_nxt = (pos_r == POS_LAST) ? POS_FIRST : pos_r + 4'h1;
    // low in the first half of the machine cycle, high in the second
    assign clk1_nxt = (pos_nxt >= POS_CLK1_HIGH);

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pos_r <= POS_LAST;
            clk1_r <= 1'b1;
        end else if (ce) begin
            pos_r <= pos_nxt;
            clk1_r <= clk1_nxt;
        end
    end

    assign pos = pos_r;
    assign first_output_clock = clk1_r;
endmodule // embc_qtimer

//--- hw/embc_hold.sv
// hold arbiter: grants the bus only between accesses and outside emulation
module embc_hold (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic hold_req_n,
    input wire logic emu_busy,
    input wire logic bus_free,
    input wire logic at_end,
    output logic grant_now,
    output logic in_hold,
    output logic hold_ack_n
);
    import embc_pkg::*;

    logic ack_n_r;
    logic ack_n_nxt;
    logic release_now;

    // a running emulator command keeps the acknowledge back
    assign grant_now = at_end && bus_free && ack_n_r && !hold_req_n &&
                       !emu_busy;
    assign release_now = at_end && !ack_n_r && hold_req_n;
    assign ack_n_nxt = grant_now ? 1'b0 : (release_now ? 1'b1 : ack_n_r);

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ack_n_r <= 1'b1;
        end else if (ce) begin
            ack_n_r <= ack_n_nxt;
        end
    end

    assign in_hold = !ack_n_r;
    assign hold_ack_n = ack_n_r;
endmodule // embc_hold

//--- hw/embc_top.sv
// external memory bus cycle sequencer for program, data and io spaces
// How it works
// - program or data space, own select each
// - io space marked by its own select
// - sixteen bit address and two-way data bus
// - ready high means one machine cycle access
// - cycle start: address, one select, read high
// - strobe falls after address setup time
// - ready sampled early in second half cycle
// - write cycle same, read/write line low
// - write data driven together with strobe
// - write data released when strobe rises
// - timing counted in quarter output clock phases
// - hold acknowledge waits for emulator command end
// - ready low adds one cycle, signals kept
// - ready high ends access at cycle end
// - on-chip accesses ignore the ready input
module embc_top (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic req_valid,
    input embc_pkg::embc_req_t req,
    output logic req_ready,
    output logic resp_valid,
    output embc_pkg::embc_resp_t resp,
    output logic [15:0] bus_addr,
    output logic program_space_select_n,
    output logic data_space_select_n,
    output logic io_space_select_n,
    output logic rw,
    output logic bus_strobe_n,
    output logic microstate_complete_n,
    output logic first_output_clock,
    input wire logic [15:0] data_in,
    output logic [15:0] data_out,
    output logic data_oe_n,
    input wire logic ready,
    input wire logic hold_req_n,
    input wire logic emu_busy,
    output logic hold_ack_n
);
    import embc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // select decode, one line low per space
    function automatic logic [2:0] sel_decode(input embc_space_t sp);
        logic [2:0] s;
        s = SEL_NONE;
        unique case (sp)
            SP_PROG: s = SEL_PROG;
            SP_DATA: s = SEL_DATA;
            SP_IO: s = SEL_IO;
            default: s = SEL_NONE;
        endcase
        return s;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // declarations
    logic [3:0] pos;
    logic clk1;
    logic grant_now;
    logic in_hold;
    logic ack_n;

    embc_state_t state_r;
    embc_state_t state_nxt;
    embc_req_t cur_r;
    embc_req_t cur_nxt;
    logic ready_seen_r;
    logic ready_seen_nxt;
    logic [3:0] waits_r;
    logic [3:0] waits_nxt;

    logic req_ready_r;
    logic req_ready_nxt;
    logic resp_valid_r;
    logic resp_valid_nxt;
    embc_resp_t resp_r;
    embc_resp_t resp_nxt;
    logic [15:0] addr_r;
    logic [15:0] addr_nxt;
    logic [2:0] sel_n_r;
    logic [2:0] sel_n_nxt;
    logic rw_r;
    logic rw_nxt;
    logic strobe_n_r;
    logic strobe_n_nxt;
    logic ustate_n_r;
    logic ustate_n_nxt;
    logic [15:0] dout_r;
    logic [15:0] dout_nxt;
    logic doe_n_r;
    logic doe_n_nxt;

    logic at_end;
    logic at_strobe;
    logic at_sample;
    logic at_clk1_rise;
    logic bus_free;
    logic take;
    logic cur_ext;
    logic finish;
    logic wait_more;
    logic [2:0] take_sel_n;
    logic start_ext;
    logic strobe_go;

    ////////////////////////////////////////////////////////////////////////
    // helpers
    embc_qtimer u_qtimer (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .ce(ce),
        .pos(pos),
        .first_output_clock(clk1)
    );

    // the bus changes hands only at machine cycle boundaries
    embc_hold u_hold (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .ce(ce),
        .hold_req_n(hold_req_n),
        .emu_busy(emu_busy),
        .bus_free(bus_free),
        .at_end(at_end),
        .grant_now(grant_now),
        .in_hold(in_hold),
        .hold_ack_n(ack_n)
    );

    ////////////////////////////////////////////////////////////////////////
    // positions within the machine cycle
    assign at_end = (pos == POS_LAST);
    assign at_strobe = (pos == POS_STROBE - 4'h1);
    assign at_sample = (pos == POS_SAMPLE);
    assign at_clk1_rise = (pos == POS_CLK1_HIGH - 4'h1);

    ////////////////////////////////////////////////////////////////////////
    // request acceptance and completion
    assign bus_free = (state_r == ST_IDLE);
    // hold wins over a new request at the same boundary
    assign take = at_end && bus_free && !in_hold && !grant_now &&
                  req_valid && req_ready_r;
    assign cur_ext = !cur_r.onchip;
    assign finish = (state_r == ST_ACCESS) && at_end && ready_seen_r;
    assign wait_more = (state_r == ST_ACCESS) && at_end && !ready_seen_r;
    assign take_sel_n = req.onchip ? SEL_NONE : sel_decode(req.space);
    // on-chip accesses leave every pin alone except microstate_complete_n
    assign start_ext = take && !req.onchip;
    assign strobe_go = (state_r == ST_ACCESS) && at_strobe && cur_ext;

    ////////////////////////////////////////////////////////////////////////
    // state
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_IDLE: begin
                if (take) begin
                    state_nxt = ST_ACCESS;
                end
            end
            ST_ACCESS: begin
                if (finish) begin
                    state_nxt = ST_IDLE;
                end
            end
        endcase
    end

    assign cur_nxt = take ? req : cur_r;
    assign req_ready_nxt = (state_nxt == ST_IDLE);

    // internal memory never waits on the pin
    assign ready_seen_nxt = take ? 1'b0 :
                            (state_r == ST_ACCESS && at_sample) ?
                            (cur_r.onchip || ready) :
                            ready_seen_r;
    // a low ready keeps the access for another machine cycle
    assign waits_nxt = take ? 4'h0 :
                       (wait_more && waits_r != WAITS_MAX) ?
                       waits_r + 4'h1 : waits_r;

    ////////////////////////////////////////////////////////////////////////
    // bus pins
    // address and data stay put after the access, only control drops
    assign addr_nxt = start_ext ? req.addr : addr_r;
    assign sel_n_nxt = take ? take_sel_n :
                       finish ? SEL_NONE : sel_n_r;
    assign rw_nxt = start_ext ? !req.write :
                    finish ? 1'b1 : rw_r;
    assign strobe_n_nxt = strobe_go ? 1'b0 :
                          finish ? 1'b1 : strobe_n_r;
    // flags the start of every operation while the output clock is low
    assign ustate_n_nxt = take ? 1'b0 : at_clk1_rise ? 1'b1 : ustate_n_r;
    assign dout_nxt = start_ext ? req.wdata : dout_r;
    // releasing on the strobe edge sits well inside the allowed window
    assign doe_n_nxt = (strobe_go && cur_r.write) ? 1'b0 :
                       finish ? 1'b1 : doe_n_r;

    ////////////////////////////////////////////////////////////////////////
    // response
    assign resp_valid_nxt = finish;
    assign resp_nxt.write = finish ? cur_r.write : resp_r.write;
    assign resp_nxt.waits = finish ? waits_r : resp_r.waits;
    // rdata keeps the last external read for the user
    // capture at the last clock leaves the memory its full access time
    assign resp_nxt.rdata = (finish && cur_ext && !cur_r.write) ?
                            data_in : resp_r.rdata;

    ////////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state_r <= ST_IDLE;
            cur_r <= '0;
        end else if (ce) begin
            state_r <= state_nxt;
            cur_r <= cur_nxt;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ready_seen_r <= 1'b0;
            waits_r <= 4'h0;
        end else if (ce) begin
            ready_seen_r <= ready_seen_nxt;
            waits_r <= waits_nxt;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            req_ready_r <= 1'b1;
        end else if (ce) begin
            req_ready_r <= req_ready_nxt;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            resp_valid_r <= 1'b0;
            resp_r <= '0;
        end else if (ce) begin
            resp_valid_r <= resp_valid_nxt;
            resp_r <= resp_nxt;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            addr_r <= ADDR_RST;
            sel_n_r <= SEL_NONE;
            rw_r <= 1'b1;
        end else if (ce) begin
            addr_r <= addr_nxt;
            sel_n_r <= sel_n_nxt;
            rw_r <= rw_nxt;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            strobe_n_r <= 1'b1;
            ustate_n_r <= 1'b1;
        end else if (ce) begin
            strobe_n_r <= strobe_n_nxt;
            ustate_n_r <= ustate_n_nxt;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            dout_r <= DATA_RST;
            doe_n_r <= 1'b1;
        end else if (ce) begin
            dout_r <= dout_nxt;
            doe_n_r <= doe_n_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign req_ready = req_ready_r;
    assign resp_valid = resp_valid_r;
    assign resp = resp_r;
    assign bus_addr = addr_r;
    assign program_space_select_n = sel_n_r[0];
    assign data_space_select_n = sel_n_r[1];
    assign io_space_select_n = sel_n_r[2];
    assign rw = rw_r;
    assign bus_strobe_n = strobe_n_r;
    assign microstate_complete_n = ustate_n_r;
    assign first_output_clock = clk1;
    assign data_out = dout_r;
    assign data_oe_n = doe_n_r;
    assign hold_ack_n = ack_n;
endmodule // embc_top

//--- testbench/embc_mem_model.sv
// static memory with wait state ready at the far side of the bus
module embc_mem_model (
    input wire logic sys_clk,
    input wire logic [15:0] bus_addr,
    input wire logic program_space_select_n,
    input wire logic data_space_select_n,
    input wire logic io_space_select_n,
    input wire logic rw,
    input wire logic bus_strobe_n,
    input wire logic first_output_clock,
    input wire logic [15:0] data_out,
    input wire logic data_oe_n,
    input wire logic [3:0] wait_cnt,
    output logic [15:0] data_in,
    output logic ready
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] mem [0:255];
    logic [15:0] last_r;
    logic [3:0] mc_cnt_r;
    logic fclk_r;
    logic sel_r;
    wire logic sel_any = !(program_space_select_n & data_space_select_n &
                           io_space_select_n);
    wire logic drive = sel_any && rw && !bus_strobe_n;
    // ready stable over whole machine cycles, low for each wait
    assign ready = (mc_cnt_r >= wait_cnt);
    // released bus shows a changing pattern, never the last value
    assign data_in = drive ? mem[bus_addr[7:0]] : ~last_r;
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = {8'h5a, 8'(i)};
        end
        last_r = 16'h0000;
        mc_cnt_r = 4'h0;
        fclk_r = 1'b1;
        sel_r = 1'b0;
    end
    always @(posedge sys_clk) begin
        fclk_r <= first_output_clock;
        sel_r <= sel_any;
        last_r <= data_in;
        if (!sel_any) begin
            mc_cnt_r <= 4'h0;
        end else if (fclk_r && !first_output_clock && sel_r) begin
            mc_cnt_r <= mc_cnt_r + 4'h1;
        end
        if (!data_oe_n && !rw && !bus_strobe_n) begin
            mem[bus_addr[7:0]] <= data_out;
        end
    end
endmodule // embc_mem_model

//--- testbench/embc_chk.sv
// concurrent checks on the pins of the external bus cycle block
module embc_chk (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic resp_valid,
    input wire logic [15:0] bus_addr,
    input wire logic program_space_select_n,
    input wire logic data_space_select_n,
    input wire logic io_space_select_n,
    input wire logic rw,
    input wire logic bus_strobe_n,
    input wire logic first_output_clock,
    input wire logic data_oe_n,
    input wire logic ready,
    input wire logic emu_busy,
    input wire logic hold_ack_n
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    wire logic [2:0] sel_low = ~{program_space_select_n, data_space_select_n,
                                 io_space_select_n};
    wire logic sel_any = |sel_low;
    sequence s_go;
        $fell(bus_strobe_n) ##3 ready;
    endsequence
    sequence s_wait;
        $fell(bus_strobe_n) ##3 !ready;
    endsequence
    sequence s_mc;
        (!first_output_clock)[*6] ##1 first_output_clock[*6];
    endsequence
    chk_one_select: assert property ($onehot0(sel_low))
        else $error("more than one space select low");
    chk_addr_setup: assert property ($fell(bus_strobe_n) |->
        $past(sel_any, 3) && !$past(sel_any, 4) && $stable(bus_addr))
        else $error("strobe fell without address setup");
    chk_no_wait: assert property (s_go |-> ##6 bus_strobe_n)
        else $error("ready access not one machine cycle");
    chk_wait_extend: assert property (s_wait |-> ##6 !bus_strobe_n)
        else $error("wait state did not extend strobe");
    chk_signals_kept: assert property (!bus_strobe_n &&
        !$past(bus_strobe_n)
        |-> $stable(bus_addr) && $stable(rw) && $stable(sel_low))
        else $error("bus signals moved during access");
    chk_write_drive: assert property ($fell(bus_strobe_n) && !rw
        |-> !data_oe_n)
        else $error("write data not driven with strobe");
    chk_drive_only: assert property (!data_oe_n
        |-> !rw && !bus_strobe_n)
        else $error("data driven outside write strobe");
    chk_end_release: assert property ($rose(bus_strobe_n)
        |-> data_oe_n && !sel_any && resp_valid)
        else $error("access end left bus held");
    chk_mc_shape: assert property ($fell(first_output_clock) |-> s_mc)
        else $error("machine cycle not twelve clocks");
    chk_hold_emu: assert property (emu_busy && hold_ack_n
        |=> hold_ack_n)
        else $error("hold granted during emulator command");
endmodule // embc_chk

//--- testbench/tb_embc_top.sv
// self-checking bench of the external bus cycle block
module tb_embc_top;
    timeunit 1ns;
    timeprecision 100ps;
    import embc_pkg::*;
    logic sys_clk, resetn, req_valid, req_ready, resp_valid, ready, rw;
    logic hold_req_n, emu_busy, hold_ack_n, bus_strobe_n, data_oe_n;
    logic program_space_select_n, data_space_select_n, io_space_select_n;
    logic microstate_complete_n, first_output_clock;
    logic [15:0] bus_addr, data_in, data_out;
    logic [3:0] wait_cnt;
    embc_req_t req;
    embc_resp_t resp;
    logic [15:0] exp_mem [0:255];
    logic [15:0] last_rd;
    logic [31:0] seed;
    int fails, n_checks;
    embc_top uut (.sys_clk(sys_clk), .resetn(resetn), .ce(1'b1),
        .req_valid(req_valid), .req(req), .req_ready(req_ready),
        .resp_valid(resp_valid), .resp(resp), .bus_addr(bus_addr),
        .program_space_select_n(program_space_select_n),
        .data_space_select_n(data_space_select_n),
        .io_space_select_n(io_space_select_n), .rw(rw),
        .bus_strobe_n(bus_strobe_n),
        .microstate_complete_n(microstate_complete_n),
        .first_output_clock(first_output_clock), .data_in(data_in),
        .data_out(data_out), .data_oe_n(data_oe_n), .ready(ready),
        .hold_req_n(hold_req_n), .emu_busy(emu_busy),
        .hold_ack_n(hold_ack_n));
    embc_mem_model mem_i (.sys_clk(sys_clk), .bus_addr(bus_addr),
        .program_space_select_n(program_space_select_n),
        .data_space_select_n(data_space_select_n),
        .io_space_select_n(io_space_select_n), .rw(rw),
        .bus_strobe_n(bus_strobe_n),
        .first_output_clock(first_output_clock), .data_out(data_out),
        .data_oe_n(data_oe_n), .wait_cnt(wait_cnt), .data_in(data_in),
        .ready(ready));
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    function automatic logic [15:0] sel_of(input embc_space_t s);
        return (s == SP_PROG) ? 16'h0003 : (s == SP_DATA) ? 16'h0005
                                                           : 16'h0006;
    endfunction
    task automatic chk_val(input string name, input logic [15:0] exp,
                           input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // one whole access; request held until the design takes it
    task automatic access(input embc_space_t sp, input logic wr,
        input logic oc, input logic [15:0] a, input logic [15:0] wd,
        input logic [3:0] w);
        int t;
        logic [3:0] ew;
        ew = oc ? 4'h0 : w;
        wait_cnt = w;
        req = '{space: sp, write: wr, onchip: oc, addr: a, wdata: wd};
        req_valid = 1'b1;
        t = 0;
        do begin
            @(posedge sys_clk);
            #1 t++;
        end while (req_ready !== 1'b0 && t < 40);
        req_valid = 1'b0;
        chk_val("select", oc ? 16'h0007 : sel_of(sp),
            {13'h0, program_space_select_n, data_space_select_n,
             io_space_select_n});
        chk_val("msc", 16'h0000, 16'(microstate_complete_n));
        if (!oc) begin
            chk_val("addr", a, bus_addr);
            chk_val("rw", 16'(!wr), 16'(rw));
        end
        t = 0;
        do begin
            @(posedge sys_clk);
            #1 t++;
        end while (resp_valid !== 1'b1 && t < 300);
        chk_val("length", 16'(12 * (1 + ew)), 16'(t));
        chk_val("waits", 16'(ew), 16'(resp.waits));
        chk_val("resp write", 16'(wr), 16'(resp.write));
        chk_val("end oe", 16'h0001, 16'(data_oe_n));
        if (!oc && wr) begin
            exp_mem[a[7:0]] = wd;
        end else if (!oc) begin
            last_rd = exp_mem[a[7:0]];
        end
        chk_val("rdata", last_rd, resp.rdata);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    initial begin
        repeat (40000) @(posedge sys_clk);
        fails++;
        give_verdict();
    end
    initial begin
        resetn = 1'b0;
        req_valid = 1'b0;
        req = '0;
        hold_req_n = 1'b1;
        emu_busy = 1'b0;
        wait_cnt = 4'h0;
        seed = 32'h083b_d6fe;
        fails = 0;
        n_checks = 0;
        last_rd = 16'h0000;
        for (int i = 0; i < 256; i++) begin
            exp_mem[i] = {8'h5a, 8'(i)};
        end
        repeat (8) @(posedge sys_clk);
        #1 resetn = 1'b1;
        access(SP_DATA, 1'b1, 1'b0, 16'h8012, 16'hbeef, 4'h0);
        access(SP_DATA, 1'b0, 1'b0, 16'h8012, 16'h0000, 4'h0);
        access(SP_IO, 1'b0, 1'b0, 16'hffff, 16'h0000, 4'hf);
        access(SP_PROG, 1'b0, 1'b1, 16'h0003, 16'h0000, 4'h3);
        for (int n = 0; n < 60; n++) begin
            seed = xs(seed);
            access(embc_space_t'(2'(seed[7:0] % 3)), seed[8],
                   seed[11:9] == 3'h0, seed[31:16], 16'(xs(seed) >> 16),
                   {2'h0, seed[13:12]});
        end
        hold_req_n = 1'b0;
        emu_busy = 1'b1;
        repeat (30) @(posedge sys_clk);
        #1 chk_val("hold emu", 16'h0001, 16'(hold_ack_n));
        emu_busy = 1'b0;
        repeat (13) @(posedge sys_clk);
        #1 chk_val("hold grant", 16'h0000, 16'(hold_ack_n));
        hold_req_n = 1'b1;
        repeat (13) @(posedge sys_clk);
        #1 chk_val("hold free", 16'h0001, 16'(hold_ack_n));
        access(SP_DATA, 1'b0, 1'b0, 16'h8012, 16'h0000, 4'h1);
        give_verdict();
    end
endmodule // tb_embc_top
bind embc_top embc_chk chk_i (.sys_clk(sys_clk), .resetn(resetn),
    .resp_valid(resp_valid), .bus_addr(bus_addr),
    .program_space_select_n(program_space_select_n),
    .data_space_select_n(data_space_select_n),
    .io_space_select_n(io_space_select_n), .rw(rw),
    .bus_strobe_n(bus_strobe_n), .first_output_clock(first_output_clock),
    .data_oe_n(data_oe_n), .ready(ready), .emu_busy(emu_busy),
    .hold_ack_n(hold_ack_n));
